/* core/at_local_regs_map.vh */
`ifndef AT_LOCAL_REGS_MAP_VH
`define AT_LOCAL_REGS_MAP_VH

// register offsets on the local bus
`define CSR_OFFSET 8'h55
`define DRV0_OFFSET 8'h56
`define DRV1_OFFSET 8'h57
`define EVT_STATUS_OFFSET 8'h59
`define EVT_MASK_OFFSET 8'h5a

// host_control_status field positions
`define CSR_ERROR_BIT 0
`define CSR_IRQEN_N_BIT 1
`define CSR_PRGRST_BIT 2
`define CSR_HD3_BIT 3
`define CSR_INT_BIT 4
`define CSR_CORRECTED_DATA_FLAG_BIT 5
`define CSR_BUFFER_TRANSFER_ACTIVE_BIT 6
`define CSR_BUSY_BIT 7

// drive status field positions
`define DRV_SEEK_BIT 0
`define DRV_FAULT_BIT 1
`define DRV_PRESENT_BIT 2
`define DRV_RWC_BIT 3
`define DRV_FORCE_BIT 4
`define DRV_USED_MSB 4

// host fixed-disk register field positions
`define FD_IRQEN_N_BIT 1
`define FD_PRGRST_BIT 2
`define FD_HD3_BIT 3

// event status / mask bit positions
`define EVT_HOST_CMD_BIT 0
`define EVT_PRGRST_BIT 1
`define EVT_BUSY_DONE_BIT 2
`define EVT_FD_WRITE_BIT 3
`define EVT_MSB 3

// reset values
`define DRV_RESET 5'h00
`define MIRROR_RESET 3'h0
`define EVT_RESET 4'h0
`define BUSY_RESET 1'b1
`define RDATA_RESET 8'h00

`endif

/* core/at_local_control_status_regs.v */
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
// Function
// - any reset clears control/status and sets busy; mirrored bits 1-3 clear on host bus reset only
// - error flag sets when a command or power-up diagnostics fail
// - error flag clears when host writes the command register, unless a command fails in that cycle
// - bit 1 mirrors host interrupt enable, active low, enabling the host irq driver
// - bit 2 mirrors host programmed reset; local side gets told of it
// - bit 3 mirrors head 3 select versus reduced write current choice
// - writing one to bit 4 raises host interrupt; bit 4 reads the line level
// - host irq per sector, dropped after each but the last, held until serviced
// - error in multi-sector transfer raises host irq and holds it to the end
// - corrected-data flag sets on correctable ECC, clears on host command write
// - buffer-transfer flag held while active; clears on last data by direction
// - busy sets on command write, diagnostic, and while any reset is active
// - busy clears on read's last sector once FIFO full and DREQ asserted
// - drive 0 register goes to host when drive 0 selected; local reset only
// - drive status bits 0-3: seek done, write fault, present, low write current
// - drive 0 force bit makes host head 3 enable read as one
// - drive 1 register identical to drive 0, shown when drive 1 selected
`include "at_local_regs_map.vh"

module at_local_control_status_regs (
    input wire clk,
    input wire rst,
    // local register port
    input wire [7:0] addr,
    input wire [7:0] writeData,
    input wire writeStrobe,
    input wire readStrobe,
    output reg [7:0] readData,
    // host bus reset pin, asynchronous to clk
    input wire host_bus_reset,
    // host-side events from logic on clk
    input wire hostCommandWrite,
    input wire hostFixedDiskWrite,
    input wire [7:0] hostFixedDiskData,
    input wire hostIrqService,
    input wire [1:0] driveSelect,
    // command engine events
    input wire diagCommand,
    input wire commandFailed,
    input wire correctableEcc,
    input wire readCommand,
    input wire sectorStart,
    input wire sectorEnd,
    input wire lastSector,
    input wire fifoFullDreq,
    input wire bufferXferStart,
    input wire xferIsDiskWrite,
    input wire lastDataToHost,
    input wire lastDataToBuffer,
    // host-facing results and the local interrupt
    output reg host_irq_line,
    output wire host_irq_line_oe,
    output wire hostProgReset,
    output wire head3_select_mirror,
    output reg [4:0] hostDriveStatus,
    output wire localIrq
);

    // ==========================================================
    // host bus reset synchroniser
    // ==========================================================
    reg hostResetMeta;
    reg hostResetSync;

    // two flops; only the second one is read by logic
    always @(posedge clk) begin
        if (rst) begin
            hostResetMeta <= 1'b0;
            hostResetSync <= 1'b0;
        end else begin
            hostResetMeta <= host_bus_reset;
            hostResetSync <= hostResetMeta;
        end
    end

    // ==========================================================
    // decode and reset combination
    // ==========================================================
    reg [2:0] fdMirror;
    reg errorFlag;
    reg cdataFlag;
    reg btrnsFlag;
    reg busy;
    reg busyPrev;
    reg errHold;
    reg prgRstPrev;
    wire [`DRV_USED_MSB:0] drive0Status;
    wire [`DRV_USED_MSB:0] drive1Status;
    reg [`EVT_MSB:0] evtStatus;
    reg [`EVT_MSB:0] evtMask;
    reg [7:0] next_readData;

    wire csrWrite;
    wire drv0Write;
    wire drv1Write;
    wire evtWrite;
    wire maskWrite;
    wire resetAll;
    wire irqEnabled;
    wire lastSectorNow;
    wire xferDoneNow;
    wire [`DRV_USED_MSB:0] selStatus;
    wire [`EVT_MSB:0] evtSet;
    wire [7:0] csrValue;
    wire busyClear;
    wire irqRaise;
    wire irqDrop;

    assign csrWrite = writeStrobe && (addr == `CSR_OFFSET);
    assign drv0Write = writeStrobe && (addr == `DRV0_OFFSET);
    assign drv1Write = writeStrobe && (addr == `DRV1_OFFSET);
    assign evtWrite = writeStrobe && (addr == `EVT_STATUS_OFFSET);
    assign maskWrite = writeStrobe && (addr == `EVT_MASK_OFFSET);

    // local, host pin or host-programmed reset all clear the flags and the irq line, and set busy
    assign hostProgReset = fdMirror[`CSR_PRGRST_BIT - 1];
    assign resetAll = rst | hostResetSync | hostProgReset;

    // interrupt enable mirror is active low
    assign irqEnabled = ~fdMirror[`CSR_IRQEN_N_BIT - 1];
    assign host_irq_line_oe = irqEnabled;

    // a sector in error counts as the last sector whatever the count says
    assign lastSectorNow = lastSector | errorFlag;

    // the end of a transfer depends on which way data flows
    assign xferDoneNow = xferIsDiskWrite ? lastDataToBuffer : lastDataToHost;

    // read-side busy release, only once the FIFO has filled for the host
    assign busyClear = readCommand && lastSectorNow && fifoFullDreq;

    // interrupt raise and per-sector drop, raise only while the host enabled it
    assign irqRaise = irqEnabled && (sectorStart || (commandFailed && btrnsFlag));
    assign irqDrop = sectorEnd && !lastSector && !errHold;

    // ==========================================================
    // mirrored host fixed-disk bits
    // ==========================================================
    // only the host pin clears these; a programmed reset must
    // not wipe the very bit that asserts it
    always @(posedge clk) begin
        if (hostResetSync) begin
            fdMirror <= `MIRROR_RESET;
        end else if (hostFixedDiskWrite) begin
            fdMirror <= {hostFixedDiskData[`FD_HD3_BIT], hostFixedDiskData[`FD_PRGRST_BIT],
                hostFixedDiskData[`FD_IRQEN_N_BIT]};
        end
    end

    // head 3 use as seen by the drive cable, with per-drive force
    assign selStatus = driveSelect[0] ? drive1Status : drive0Status;
    assign head3_select_mirror = fdMirror[`CSR_HD3_BIT - 1] | selStatus[`DRV_FORCE_BIT];

    // ==========================================================
    // error and corrected-data flags
    // ==========================================================
    // failure event wins over a clear in the same cycle
    always @(posedge clk) begin
        if (resetAll) begin
            errorFlag <= 1'b0;
        end else if (commandFailed) begin
            errorFlag <= 1'b1;
        end else if (hostCommandWrite) begin
            errorFlag <= 1'b0;
        end else if (csrWrite) begin
            errorFlag <= writeData[`CSR_ERROR_BIT];
        end
    end

    always @(posedge clk) begin
        if (resetAll) begin
            cdataFlag <= 1'b0;
        end else if (correctableEcc) begin
            cdataFlag <= 1'b1;
        end else if (hostCommandWrite) begin
            cdataFlag <= 1'b0;
        end else if (csrWrite) begin
            cdataFlag <= writeData[`CSR_CORRECTED_DATA_FLAG_BIT];
        end
    end

    // ==========================================================
    // buffer transfer flag, read only
    // ==========================================================
    always @(posedge clk) begin
        if (resetAll) begin
            btrnsFlag <= 1'b0;
        end else if (bufferXferStart) begin
            btrnsFlag <= 1'b1;
        end else if (xferDoneNow) begin
            btrnsFlag <= 1'b0;
        end
    end

    // ==========================================================
    // busy flag
    // ==========================================================
    // busy is held high for as long as any reset lasts
    always @(posedge clk) begin
        if (resetAll) begin
            busy <= `BUSY_RESET;
        end else if (hostCommandWrite || diagCommand) begin
            busy <= 1'b1;
        end else if (busyClear) begin
            busy <= 1'b0;
        end else if (csrWrite) begin
            busy <= writeData[`CSR_BUSY_BIT];
        end
    end

    // ==========================================================
    // host interrupt sequencing
    // ==========================================================
    // errHold keeps the line up from an error to the end of the last sector
    always @(posedge clk) begin
        if (resetAll) begin
            errHold <= 1'b0;
        end else if (commandFailed && btrnsFlag) begin
            errHold <= 1'b1;
        end else if (sectorEnd && lastSector) begin
            errHold <= 1'b0;
        end
    end

    // raising sources win over the drop and the service clear
    always @(posedge clk) begin
        if (resetAll) begin
            host_irq_line <= 1'b0;
        end else if (csrWrite && writeData[`CSR_INT_BIT]) begin
            host_irq_line <= 1'b1;
        end else if (irqRaise) begin
            host_irq_line <= 1'b1;
        end else if (irqDrop) begin
            host_irq_line <= 1'b0;
        end else if (hostIrqService && !errHold) begin
            host_irq_line <= 1'b0;
        end
    end

    // ==========================================================
    // drive status registers
    // ==========================================================
    // both drives share one register design; bits above the force bit are not stored
    drive_status_reg #(
        .WIDTH(`DRV_USED_MSB + 1)
    ) i_drive0 (
        .clk(clk),
        .rst(rst),
        .load(drv0Write),
        .loadData(writeData[`DRV_USED_MSB:0]),
        .value(drive0Status)
    );

    drive_status_reg #(
        .WIDTH(`DRV_USED_MSB + 1)
    ) i_drive1 (
        .clk(clk),
        .rst(rst),
        .load(drv1Write),
        .loadData(writeData[`DRV_USED_MSB:0]),
        .value(drive1Status)
    );

    // host view follows the drive number field, registered for a clean bus
    always @(posedge clk) begin
        if (rst) begin
            hostDriveStatus <= `DRV_RESET;
        end else begin
            hostDriveStatus <= selStatus;
        end
    end

    // ==========================================================
    // local interrupt: sticky events, mask, one level output
    // ==========================================================
    always @(posedge clk) begin
        if (rst) begin
            busyPrev <= 1'b0;
            prgRstPrev <= 1'b0;
        end else begin
            busyPrev <= busy;
            prgRstPrev <= hostProgReset;
        end
    end

    // programmed reset rising is how firmware learns of it
    assign evtSet = {hostFixedDiskWrite,
        busyPrev & ~busy,
        hostProgReset & ~prgRstPrev,
        hostCommandWrite};

    // write one clears, but a fresh event in that cycle stays set
    always @(posedge clk) begin
        if (rst) begin
            evtStatus <= `EVT_RESET;
        end else if (evtWrite) begin
            evtStatus <= (evtStatus & ~writeData[`EVT_MSB:0]) | evtSet;
        end else begin
            evtStatus <= evtStatus | evtSet;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            evtMask <= `EVT_RESET;
        end else if (maskWrite) begin
            evtMask <= writeData[`EVT_MSB:0];
        end
    end

    assign localIrq = |(evtStatus & evtMask);

    // ==========================================================
    // read path
    // ==========================================================
    // bit 4 shows the line itself, not the last value written
    assign csrValue = {busy, btrnsFlag, cdataFlag, host_irq_line, fdMirror, errorFlag};

    // data stands one cycle after the strobe and is zero otherwise;
    // these registers only make sense once firmware has left XT mode
    always @* begin
        next_readData = `RDATA_RESET;
        if (readStrobe) begin
            case (addr)
                `CSR_OFFSET: next_readData = csrValue;
                `DRV0_OFFSET: next_readData = {3'h0, drive0Status};
                `DRV1_OFFSET: next_readData = {3'h0, drive1Status};
                `EVT_STATUS_OFFSET: next_readData = {4'h0, evtStatus};
                `EVT_MASK_OFFSET: next_readData = {4'h0, evtMask};
                default: next_readData = `RDATA_RESET;
            endcase
        end
    end

    // registered so software always samples a settled value
    always @(posedge clk) begin
        if (rst) begin
            readData <= `RDATA_RESET;
        end else begin
            readData <= next_readData;
        end
    end

endmodule // at_local_control_status_regs

// ==========================================================
// one drive status register
// ==========================================================
module drive_status_reg #(
    parameter WIDTH = 5
) (
    input wire clk,
    input wire rst,
    input wire load,
    input wire [WIDTH-1:0] loadData,
    output reg [WIDTH-1:0] value
);

    // host and programmed resets leave drive state alone
    always @(posedge clk) begin
        if (rst) begin
            value <= `DRV_RESET;
        end else if (load) begin
            value <= loadData;
        end
    end

endmodule // drive_status_reg

/* test/at_local_regs_properties.sv */
`timescale 1ns/100ps
// ==========
// port-level checks of the local control/status bank
module at_local_regs_properties (
    input wire clk,
    input wire rst,
    input wire [7:0] addr,
    input wire writeStrobe,
    input wire readStrobe,
    input wire [7:0] readData,
    input wire host_bus_reset,
    input wire hostCommandWrite,
    input wire commandFailed,
    input wire correctableEcc,
    input wire sectorStart,
    input wire fifoFullDreq,
    input wire [1:0] driveSelect,
    input wire host_irq_line,
    input wire host_irq_line_oe,
    input wire hostProgReset,
    input wire head3_select_mirror,
    input wire [4:0] hostDriveStatus
);
    // pin history spans the synchroniser, so host reset is excluded while in flight
    logic [3:0] hrHist;
    wire csrRd = readStrobe && addr == 8'h55;
    always @(posedge clk) begin
        hrHist <= {hrHist[2:0], host_bus_reset};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_read_idle: assert property (!$past(readStrobe) |-> readData == 8'h00)
        else $error("readData not idle");
    chk_unmapped_zero: assert property (readStrobe && !(addr inside {8'h55, 8'h56, 8'h57, 8'h59, 8'h5a})
        |=> readData == 8'h00) else $error("unmapped read not zero");
    chk_drv_reserved: assert property (
        readStrobe && addr[7:1] == 7'h2b |=> readData[7:5] == 3'h0) else $error("reserved bits set");
    chk_drv_select: assert property (
        readStrobe && addr[7:1] == 7'h2b && addr[0] == driveSelect[0] && !$past(writeStrobe)
        |=> hostDriveStatus == readData[4:0]) else $error("host drive status mismatch");
    chk_irqen_mirror: assert property (
        csrRd |=> readData[1] == !$past(host_irq_line_oe)) else $error("enable mirror mismatch");
    chk_prgrst_mirror: assert property (
        csrRd |=> readData[2] == $past(hostProgReset)) else $error("reset mirror mismatch");
    chk_irq_readback: assert property (
        csrRd |=> readData[4] == $past(host_irq_line)) else $error("irq readback mismatch");
    chk_sector_irq: assert property (
        sectorStart && host_irq_line_oe && !hostProgReset && !host_bus_reset && hrHist == 4'h0
        |=> host_irq_line) else $error("sector irq missing");
    chk_busy_on_cmd: assert property (
        csrRd && $past(hostCommandWrite, 2) && !$past(writeStrobe) && !$past(fifoFullDreq)
        && !$past(commandFailed, 2) && !$past(correctableEcc, 2) && !$past(commandFailed) && !$past(correctableEcc)
        |=> readData[7] && !readData[0] && !readData[5]) else $error("command write flags wrong");
    chk_prgrst_clears: assert property (
        csrRd && hostProgReset && $past(hostProgReset) |=> readData[7] && readData[6:5] == 2'h0 && !readData[0])
        else $error("programmed reset flags wrong");
    chk_head3_force: assert property (
        hostDriveStatus[4] && !$past(writeStrobe) && $past(driveSelect) == driveSelect |-> head3_select_mirror)
        else $error("head 3 force ignored");
    cover property (sectorStart && host_irq_line_oe);
    cover property (csrRd && hostProgReset);
    cover property (hostDriveStatus[4] && head3_select_mirror);
endmodule // at_local_regs_properties
bind at_local_control_status_regs at_local_regs_properties i_props (.clk, .rst, .addr, .writeStrobe,
    .readStrobe, .readData, .host_bus_reset, .hostCommandWrite, .commandFailed, .correctableEcc, .sectorStart,
    .fifoFullDreq, .driveSelect, .host_irq_line, .host_irq_line_oe, .hostProgReset, .head3_select_mirror,
    .hostDriveStatus);

/* test/host_bus_model.sv */
`timescale 1ns/100ps
// ==========
// AT host side; only AT register cycles are ever issued
module host_bus_model (
    input wire clk,
    output logic host_bus_reset = 1'b0,
    output logic hostCommandWrite = 1'b0,
    output logic hostFixedDiskWrite = 1'b0,
    output logic [7:0] hostFixedDiskData = 8'h00,
    output logic hostIrqService = 1'b0,
    output logic [1:0] driveSelect = 2'h0
);
    // pin held past the two-flop synchroniser
    task hreset();
        @(posedge clk);
        host_bus_reset <= 1'b1;
        repeat (4) @(posedge clk);
        host_bus_reset <= 1'b0;
        repeat (4) @(posedge clk);
        #5;
    endtask
    task cmd();
        @(posedge clk);
        hostCommandWrite <= 1'b1;
        @(posedge clk);
        hostCommandWrite <= 1'b0;
        #5;
    endtask
    // data inverted after the strobe so a late sample is caught
    task fd(input logic [7:0] d);
        @(posedge clk);
        hostFixedDiskWrite <= 1'b1;
        hostFixedDiskData <= d;
        @(posedge clk);
        hostFixedDiskWrite <= 1'b0;
        hostFixedDiskData <= ~d;
        #5;
    endtask
    task service();
        @(posedge clk);
        hostIrqService <= 1'b1;
        @(posedge clk);
        hostIrqService <= 1'b0;
        #5;
    endtask
    task sel(input logic [1:0] s);
        @(posedge clk);
        driveSelect <= s;
        @(posedge clk);
        #5;
    endtask
endmodule // host_bus_model

/* test/at_local_control_status_regs_tb_top.sv */
`timescale 1ns/100ps
module at_local_control_status_regs_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] writeData = 8'h00;
    logic writeStrobe = 1'b0;
    logic readStrobe = 1'b0;
    logic [7:0] ev = 8'h00;
    logic readCommand = 1'b0, lastSector = 1'b0, fifoFullDreq = 1'b0, xferIsDiskWrite = 1'b0;
    wire [7:0] readData, hostFixedDiskData;
    wire [4:0] hostDriveStatus;
    wire [1:0] driveSelect;
    wire host_irq_line, host_irq_line_oe, hostProgReset, head3_select_mirror, localIrq;
    wire host_bus_reset, hostCommandWrite, hostFixedDiskWrite, hostIrqService;
    int n_mismatch = 0, compares = 0, cycles = 0;
    logic [31:0] seed = 32'h00006b4b;
    logic [7:0] expQ[$], adrQ[$];
    logic pend = 1'b0;
    localparam logic [7:0] eDiag = 8'h01, eFail = 8'h02, eEcc = 8'h04, eStart = 8'h08;
    localparam logic [7:0] eEnd = 8'h10, eXfer = 8'h20, eHost = 8'h40, eBuf = 8'h80;
    always #20 clk = ~clk;
    host_bus_model i_host (.clk, .host_bus_reset, .hostCommandWrite, .hostFixedDiskWrite, .hostFixedDiskData,
        .hostIrqService, .driveSelect);
    at_local_control_status_regs i_dut (.clk, .rst, .addr, .writeData, .writeStrobe, .readStrobe, .readData,
        .host_bus_reset, .hostCommandWrite, .hostFixedDiskWrite, .hostFixedDiskData, .hostIrqService, .driveSelect,
        .diagCommand(ev[0]), .commandFailed(ev[1]), .correctableEcc(ev[2]), .readCommand, .sectorStart(ev[3]),
        .sectorEnd(ev[4]), .lastSector, .fifoFullDreq, .bufferXferStart(ev[5]), .xferIsDiskWrite,
        .lastDataToHost(ev[6]), .lastDataToBuffer(ev[7]), .host_irq_line, .host_irq_line_oe, .hostProgReset,
        .head3_select_mirror, .hostDriveStatus, .localIrq);
    // ==========
    // helpers; every driver task ends settled, off the edge
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task cmp(input string what, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clk);
        writeStrobe <= 1'b0;
        #5;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        readStrobe <= 1'b1;
        expQ.push_back(e);
        adrQ.push_back(a);
        @(posedge clk);
        readStrobe <= 1'b0;
        #5;
    endtask
    task pulse(input logic [7:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 8'h00;
        #5;
    endtask
    // levels: read command, last sector, fifo full, disk write direction
    task lv(input logic [3:0] v);
        @(posedge clk);
        readCommand <= v[3];
        lastSector <= v[2];
        fifoFullDreq <= v[1];
        xferIsDiskWrite <= v[0];
        #5;
    endtask
    task tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // read replies stand one cycle after the strobe; oldest note is matched
    always @(posedge clk) begin
        if (pend) cmp($sformatf("readData at %h", adrQ.pop_front()), expQ.pop_front(), readData);
        pend <= readStrobe;
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        i_host.hreset();
        rd(8'h55, 8'h80);
        rd(8'h70, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            logic [7:0] r;
            r = rnd();
            wr(8'h56 + i[0], r);
            rd(8'h56 + i[0], {3'h0, r[4:0]});
        end
        wr(8'h56, 8'hf0);
        wr(8'h57, 8'h0f);
        i_host.sel(2'h0);
        cmp("drive0 status", 8'h10, hostDriveStatus);
        cmp("head3 force", 8'h01, head3_select_mirror);
        i_host.sel(2'h1);
        cmp("drive1 status", 8'h0f, hostDriveStatus);
        cmp("head3 unforced", 8'h00, head3_select_mirror);
        $display("test drives done");
        i_host.fd(8'h0e);
        cmp("prog reset", 8'h01, hostProgReset);
        cmp("irq driver", 8'h00, host_irq_line_oe);
        cmp("head3 mirror", 8'h01, head3_select_mirror);
        rd(8'h55, 8'h8e);
        i_host.fd(8'h08);
        rd(8'h55, 8'h88);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'h55, 8'h88);
        rd(8'h56, 8'h00);
        rd(8'h57, 8'h00);
        i_host.hreset();
        rd(8'h55, 8'h80);
        cmp("irq driver", 8'h01, host_irq_line_oe);
        $display("test mirrors done");
        wr(8'h55, 8'h00);
        pulse(eFail);
        pulse(eEcc);
        rd(8'h55, 8'h21);
        i_host.cmd();
        rd(8'h55, 8'h80);
        wr(8'h5a, 8'h0f);
        cmp("localIrq", 8'h01, localIrq);
        rd(8'h59, 8'h05);
        wr(8'h5a, 8'h00);
        cmp("localIrq masked", 8'h00, localIrq);
        wr(8'h5a, 8'h0f);
        wr(8'h59, 8'h0f);
        cmp("localIrq cleared", 8'h00, localIrq);
        $display("test flags done");
        lv(4'he);
        rd(8'h55, 8'h00);
        cmp("localIrq busy fell", 8'h01, localIrq);
        wr(8'h59, 8'h04);
        lv(4'h0);
        pulse(eDiag);
        rd(8'h55, 8'h80);
        wr(8'h55, 8'h10);
        cmp("sw irq", 8'h01, host_irq_line);
        rd(8'h55, 8'h10);
        i_host.service();
        cmp("irq serviced", 8'h00, host_irq_line);
        pulse(eStart);
        cmp("sector irq", 8'h01, host_irq_line);
        pulse(eEnd);
        cmp("sector end", 8'h00, host_irq_line);
        pulse(eStart);
        lv(4'h4);
        pulse(eEnd);
        cmp("last sector", 8'h01, host_irq_line);
        i_host.service();
        cmp("last serviced", 8'h00, host_irq_line);
        $display("test irq done");
        lv(4'h0);
        pulse(eXfer);
        rd(8'h55, 8'h40);
        pulse(eFail);
        cmp("error irq", 8'h01, host_irq_line);
        pulse(eEnd);
        i_host.service();
        cmp("error hold", 8'h01, host_irq_line);
        lv(4'h4);
        pulse(eEnd);
        i_host.service();
        cmp("error released", 8'h00, host_irq_line);
        pulse(eHost);
        rd(8'h55, 8'h01);
        lv(4'h1);
        pulse(eXfer);
        pulse(eHost);
        rd(8'h55, 8'h41);
        pulse(eBuf);
        rd(8'h55, 8'h01);
        i_host.fd(8'h04);
        rd(8'h55, 8'h84);
        i_host.fd(8'h00);
        rd(8'h55, 8'h80);
        rd(8'h59, 8'h0e);
        $display("test transfers done");
        repeat (3) @(posedge clk);
        tally_and_finish();
    end
endmodule // at_local_control_status_regs_tb_top
